// [rtl/lux_conv.sv]
// Light sensor command and readout top, with its converter model
// Behaviour
// - A command starts at once; readings update only when a conversion completes.
// - A read during conversion returns the previous completed result.
// - Command register holds until overwritten; address-only write leaves it unchanged and triggers nothing.
// - Read is address plus read bit; device drives SDA for up to 4 bytes.
// - Read order: reading low, reading high, counter low, counter high.
// - Counter bytes only in external timing; otherwise stop after two bytes.
// - Internal timing: device times each conversion itself, nominally 110 ms.
// - External timing: each timing command ends one integration and starts the next.
// - Command 0x8c powers the converter down; any later conversion command re-enables it.
// - Command 0x0c clears the conversion count and the cycle count.
// - Internal commands 0x00, 0x04, 0x08 select visible, dark, difference.
// - External commands 0x30, 0x34, 0x38 select visible, dark, difference.
// - A command with its top bit set, other than 0x8c, is stored and read back.
// - Oscillator increments a 16-bit counter, latched at each conversion end.
// - In internal timing, difference mode integrates dark first, then visible; output is visible minus dark.
// - Address is 1000 in the upper bits, lower three from select pins.
`timescale 1ns/1ps
`default_nettype none
module lux_conv import lux_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic osc_tick_i,
  input wire logic vis_pulse_i,
  input wire logic dark_pulse_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic ext_mode_i,
  input wire logic ext_mark_i,
  input wire lux_pkg::src_t src_i,
  output logic done_o,
  output logic [CNT_W-1:0] result_o,
  output logic [CNT_W-1:0] cycles_o
);
  typedef struct packed {
    logic [CNT_W-1:0] acc;
    logic [CNT_W-1:0] osc;
    logic [CNT_W-1:0] res;
    logic [CNT_W-1:0] cyc;
    logic phase;
    logic done;
  } state_t;
  state_t q, d;
  localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INT_CYCLES - 1);
  logic end_int;
  always_comb begin
    d = q;
    d.done = 1'b0;
    end_int = ext_mode_i ? ext_mark_i : (osc_tick_i && q.osc == INT_LAST);
    if (clear_i) begin
      d.acc = '0;
      d.osc = '0;
      d.phase = 1'b0;
    end else if (enable_i) begin
      if (osc_tick_i) d.osc = q.osc + CNT_W'(1);
      // Difference mode takes dark first, counting down, then visible up;
      // external timing has no second half, so both diodes count together
      if (src_i == SRC_DIFF) begin
        if ((ext_mode_i || !q.phase) && dark_pulse_i) d.acc = d.acc - CNT_W'(1);
        if ((ext_mode_i || q.phase) && vis_pulse_i) d.acc = d.acc + CNT_W'(1);
      end else if ((src_i == SRC_VIS) ? vis_pulse_i : dark_pulse_i) begin
        d.acc = q.acc + CNT_W'(1);
      end
      if (end_int) begin
        if (src_i == SRC_DIFF && !q.phase && !ext_mode_i) begin
          d.osc = '0;
          d.phase = 1'b1;
        end else begin
          d.res = d.acc;
          // Counts this cycle's tick too, so it pairs with the reading
          d.cyc = d.osc;
          d.osc = '0;
          d.acc = '0;
          d.phase = 1'b0;
          d.done = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) q <= '0;
    else q <= d;
  end
  res_update_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $changed(q.res) |-> q.done)
    else $error("Reading changed outside a completed conversion");
  assign done_o = q.done;
  assign result_o = q.res;
  assign cycles_o = q.cyc;
endmodule // lux_conv

module lux_sensor import lux_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] addr_sel_i,
  input wire logic osc_tick_i,
  input wire logic vis_pulse_i,
  input wire logic dark_pulse_i,
  output logic sda_oe_o
);
  // Byte layout of the readout is fixed, so the counter width is too
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  function automatic logic is_ext(input logic [BYTE_W-1:0] c);
    return c == CMD_EXT_VIS || c == CMD_EXT_DARK || c == CMD_EXT_DIFF;
  endfunction
  function automatic logic is_int(input logic [BYTE_W-1:0] c);
    return c == CMD_INT_VIS || c == CMD_INT_DARK || c == CMD_INT_DIFF;
  endfunction
  function automatic logic is_test(input logic [BYTE_W-1:0] c);
    return c[TEST_BIT] && c != CMD_POWER_DOWN;
  endfunction
  function automatic src_t src_of(input logic [BYTE_W-1:0] c);
    if (c == CMD_INT_DARK || c == CMD_EXT_DARK) return SRC_DARK;
    if (c == CMD_INT_DIFF || c == CMD_EXT_DIFF) return SRC_DIFF;
    return SRC_VIS;
  endfunction
  function automatic logic [BYTE_W-1:0] pick_byte(input logic [2*CNT_W-1:0] s,
                                                   input logic [1:0] i);
    case (i)
      REG_READ_LO: return s[BYTE_W-1:0];
      REG_READ_HI: return s[CNT_W-1:BYTE_W];
      REG_CNT_LO: return s[CNT_W+BYTE_W-1:CNT_W];
      default: return s[2*CNT_W-1:CNT_W+BYTE_W];
    endcase
  endfunction
  typedef struct packed {
    logic [BYTE_W-1:0] cmd;
    logic pwr_dn;
    logic mark;
    logic clr;
    logic [1:0] idx;
    logic [2*CNT_W-1:0] snap;
    logic [BYTE_W-1:0] tx;
  } state_t;
  state_t q, d;
  logic wr_byte, rd_start, tx_next, tx_last;
  logic [BYTE_W-1:0] rx_byte;
  logic [CNT_W-1:0] result, cycles;
  always_comb begin
    d = q;
    d.mark = 1'b0;
    d.clr = 1'b0;
    if (wr_byte) begin
      d.cmd = rx_byte;
      d.pwr_dn = (rx_byte == CMD_POWER_DOWN);
      d.clr = (rx_byte == CMD_RESET);
      d.mark = is_ext(rx_byte);
    end
    // Snapshot at the read address, so low and high bytes never mix conversions
    if (rd_start) begin
      d.idx = REG_READ_LO;
      d.snap = {cycles, result};
    end else if (tx_next) begin
      d.idx = q.idx + 2'h1;
    end
    d.tx = is_test(q.cmd) ? q.cmd : pick_byte(q.snap, q.idx);
    tx_last = is_ext(q.cmd) ? (q.idx == REG_CNT_HI) : (q.idx == REG_READ_HI);
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  lux_i2c_slave i_slave (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .dev_addr_i({ADDR_UPPER, addr_sel_i}),
    .tx_byte_i(q.tx),
    .tx_last_i(tx_last),
    .sda_oe_o(sda_oe_o),
    .wr_addr_o(),
    .wr_byte_o(wr_byte),
    .rx_byte_o(rx_byte),
    .rd_start_o(rd_start),
    .tx_next_o(tx_next)
  );
  lux_conv #(.CNT_W(CNT_W)) i_conv (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .osc_tick_i(osc_tick_i),
    .vis_pulse_i(vis_pulse_i),
    .dark_pulse_i(dark_pulse_i),
    .enable_i(!q.pwr_dn && (is_ext(q.cmd) || is_int(q.cmd))),
    .clear_i(q.clr),
    .ext_mode_i(is_ext(q.cmd)),
    .ext_mark_i(q.mark),
    .src_i(src_of(q.cmd)),
    .done_o(),
    .result_o(result),
    .cycles_o(cycles)
  );
  cmd_load_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_byte |=> q.cmd == $past(rx_byte))
    else $error("Command byte not stored");
  cmd_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !wr_byte |=> $stable(q.cmd))
    else $error("Command changed without a new byte");
  pwr_down_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_byte |=> q.pwr_dn == ($past(rx_byte) == CMD_POWER_DOWN))
    else $error("Power-down state does not follow the last command");
  snap_take_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    rd_start |=> q.snap == $past({cycles, result}))
    else $error("Readout snapshot not taken at read start");
  int_stop_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tx_next && !is_ext(q.cmd) |-> q.idx == REG_READ_LO)
    else $error("Counter bytes offered outside external timing");
endmodule // lux_sensor
`default_nettype wire

// [rtl/lux_pkg.sv]
// Shared constants for the light sensor command and readout block
package lux_pkg;
  localparam logic [3:0] ADDR_UPPER = 4'h8;
  localparam logic [7:0] CMD_POWER_DOWN = 8'h8c;
  localparam logic [7:0] CMD_RESET = 8'h0c;
  localparam logic [7:0] CMD_INT_VIS = 8'h00;
  localparam logic [7:0] CMD_INT_DARK = 8'h04;
  localparam logic [7:0] CMD_INT_DIFF = 8'h08;
  localparam logic [7:0] CMD_EXT_VIS = 8'h30;
  localparam logic [7:0] CMD_EXT_DARK = 8'h34;
  localparam logic [7:0] CMD_EXT_DIFF = 8'h38;
  localparam int TEST_BIT = 7;
  localparam logic [1:0] REG_READ_LO = 2'h0;
  localparam logic [1:0] REG_READ_HI = 2'h1;
  localparam logic [1:0] REG_CNT_LO = 2'h2;
  localparam logic [1:0] REG_CNT_HI = 2'h3;
  localparam int INT_CYCLES = 32768;
  localparam int CONV_TIME_MS = 110;
  localparam int EXT_MIN_MS = 1;
  localparam int EXT_MAX_MS = 100;
  localparam int READ_WAIT_MS = 120;
  typedef enum logic [1:0] {
    SRC_VIS,
    SRC_DARK,
    SRC_DIFF
  } src_t;
endpackage

// [rtl/lux_i2c_slave.sv]
// Byte-level I2C target: address match, receive, transmit with ack
`timescale 1ns/1ps
`default_nettype none
module lux_i2c_slave (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] dev_addr_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  output logic sda_oe_o,
  output logic wr_addr_o,
  output logic wr_byte_o,
  output logic [7:0] rx_byte_o,
  output logic rd_start_o,
  output logic tx_next_o
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ACK,
    S_RX,
    S_TX,
    S_TXACK
  } st_t;
  typedef struct packed {
    logic scl_p;
    logic sda_p;
    st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic oe;
    logic wa;
    logic wb;
    logic rs;
    logic tn;
  } state_t;
  state_t q, d;
  logic rise, fall, start, stop;
  always_comb begin
    rise = scl_i & ~q.scl_p;
    fall = ~scl_i & q.scl_p;
    start = scl_i & q.scl_p & q.sda_p & ~sda_i;
    stop = scl_i & q.scl_p & ~q.sda_p & sda_i;
    d = q;
    d.scl_p = scl_i;
    d.sda_p = sda_i;
    d.wa = 1'b0;
    d.wb = 1'b0;
    d.rs = 1'b0;
    d.tn = 1'b0;
    if (stop) begin
      d.st = S_IDLE;
      d.oe = 1'b0;
    end else if (start) begin
      d.st = S_ADDR;
      d.cnt = 4'h0;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        S_IDLE: d.oe = 1'b0;
        S_ADDR, S_RX: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda_i};
            d.cnt = q.cnt + 4'h1;
          end
          if (fall && q.cnt == 4'h8) begin
            d.cnt = 4'h0;
            if (q.st == S_ADDR) begin
              if (q.sh[7:1] == dev_addr_i) begin
                d.oe = 1'b1;
                d.rd = q.sh[0];
                d.st = S_ACK;
                d.wa = ~q.sh[0];
                d.rs = q.sh[0];
              end else begin
                d.st = S_IDLE;
              end
            end else begin
              d.oe = 1'b1;
              d.st = S_ACK;
              d.wb = 1'b1;
            end
          end
        end
        S_ACK: if (fall) begin
          if (q.rd) begin
            d.st = S_TX;
            d.sh = tx_byte_i;
            d.oe = ~tx_byte_i[7];
            d.cnt = 4'h1;
          end else begin
            d.oe = 1'b0;
            d.st = S_RX;
          end
        end
        S_TX: if (fall) begin
          if (q.cnt == 4'h8) begin
            d.oe = 1'b0;
            d.st = S_TXACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
            d.cnt = q.cnt + 4'h1;
          end
        end
        S_TXACK: if (rise) begin
          // Master nack, or no bytes left: release SDA until stop
          if (sda_i || tx_last_i) begin
            d.st = S_IDLE;
          end else begin
            d.st = S_ACK;
            d.tn = 1'b1;
          end
        end
        default: d.st = S_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end
  rd_ack_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    q.rs |-> q.st == S_ACK && q.oe)
    else $error("Read address not acknowledged");
  assign sda_oe_o = q.oe;
  assign wr_addr_o = q.wa;
  assign wr_byte_o = q.wb;
  assign rx_byte_o = q.sh;
  assign rd_start_o = q.rs;
  assign tx_next_o = q.tn;
endmodule // lux_i2c_slave
`default_nettype wire

// [tb/i2c_master_model.sv]
// Behavioural I2C bus master that stands opposite the sensor front end
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Quarter bit of 12 clocks keeps every edge on a falling system clock edge
  task automatic clk_bit(input logic low, output logic b);
    sda_low_o = low;
    #96 scl_o = 1'b1;
    #96 b = sda_i;
    #96 scl_o = 1'b0;
    #96;
  endtask
  task automatic start;
    #96 sda_low_o = 1'b1;
    #96 scl_o = 1'b0;
  endtask
  task automatic stop;
    sda_low_o = 1'b1;
    #96 scl_o = 1'b1;
    #96 sda_low_o = 1'b0;
    #96;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) clk_bit(!d[i], b);
    clk_bit(1'b0, b);
    ack = !b;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, b);
      d[i] = b;
    end
    clk_bit(!last, b);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the I2C target of the light sensor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lux_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] addr_sel = 3'h4;
  logic [7:0] cmds [9] = '{8'h8c, 8'h0c, 8'h00, 8'h04, 8'h08, 8'h30, 8'h34, 8'h38, 8'ha5};
  logic [7:0] got [4];
  logic [7:0] n_lo, n_hi;
  logic scl, sda_low, sda_oe, ack;
  logic osc = 1'b0;
  logic dark = 1'b0;
  wire sda = !(sda_low | sda_oe);
  int mismatches = 0;
  int comparisons = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  // Visible pulses follow the oscillator, so reading and cycle count must agree
  always @(negedge sys_clk_i) begin
    if (nrst_i) osc <= ~osc;
  end
  lux_sensor i_dut (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .scl_i(scl),
    .sda_i(sda),
    .addr_sel_i(addr_sel),
    .osc_tick_i(osc),
    .vis_pulse_i(osc),
    .dark_pulse_i(dark),
    .sda_oe_o(sda_oe)
  );
  i2c_master_model i_master(.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_cmd(input logic [7:0] c);
    i_master.start();
    i_master.send({ADDR_UPPER, 3'h4, 1'b0}, ack);
    chk({7'h0, ack}, 8'h01);
    i_master.send(c, ack);
    chk({7'h0, ack}, 8'h01);
    i_master.stop();
  endtask
  task automatic rd_bytes(input int n);
    i_master.start();
    i_master.send({ADDR_UPPER, 3'h4, 1'b1}, ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) i_master.recv(i == n - 1, got[i]);
    i_master.stop();
  endtask
  initial begin
    repeat (6) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    i_master.start();
    i_master.send(8'h8a, ack);
    i_master.stop();
    chk({7'h0, ack}, 8'h00);
    foreach (cmds[k]) wr_cmd(cmds[k]);
    rd_bytes(3);
    chk(got[0], 8'ha5);
    chk(got[1], 8'ha5);
    chk(got[2], 8'hff);
    i_master.start();
    i_master.send(8'h88, ack);
    i_master.stop();
    rd_bytes(2);
    chk(got[0], 8'ha5);
    wr_cmd(CMD_RESET);
    wr_cmd(CMD_EXT_DARK);
    wr_cmd(CMD_EXT_DARK);
    rd_bytes(4);
    chk({got[1], got[0]}, 16'h0000);
    chk({7'h0, (got[2] | got[3]) != 8'h00}, 8'h01);
    wr_cmd(CMD_EXT_VIS);
    wr_cmd(CMD_EXT_VIS);
    rd_bytes(4);
    chk(got[0], got[2]);
    chk(got[1], got[3]);
    chk({7'h0, (got[0] | got[1]) != 8'h00}, 8'h01);
    n_lo = got[0];
    n_hi = got[1];
    // Read well before the internal period ends, against the usual wait
    wr_cmd(CMD_INT_VIS);
    rd_bytes(2);
    chk(got[0], n_lo);
    chk(got[1], n_hi);
    wr_cmd(CMD_POWER_DOWN);
    rd_bytes(2);
    chk(got[0], n_lo);
    wr_cmd(CMD_INT_DARK);
    finish_test();
  end
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
